/* File: bench/dfs_host.sv */
// command host model: commands, fault reset and halt request
`timescale 1ns/1ns
module dfs_host (
  input wire clk,
  input wire rsp_valid,
  input wire rsp_ok,
  input wire [15:0] rsp_code,
  output reg cmd_valid,
  output reg [2:0] cmd_code,
  output reg fault_reset,
  output reg halt_req
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 3'h7;
    fault_reset = 1'b0;
    halt_req = 1'b0;
  end
  // one command, answer taken the cycle after the taking edge
  task send(input [2:0] code, output ok, output [15:0] rc, output got);
    begin
      @(negedge clk);
      cmd_code = code;
      cmd_valid = 1'b1;
      @(negedge clk);
      got = rsp_valid;
      ok = rsp_ok;
      rc = rsp_code;
      cmd_valid = 1'b0;
      // idle code lines flip so nothing leans on a stale value
      cmd_code = ~code;
    end
  endtask
  task clear;
    begin
      @(negedge clk);
      fault_reset = 1'b1;
      @(negedge clk);
      fault_reset = 1'b0;
    end
  endtask
  // held until the bench says standstill, or dropped early on purpose
  task halt(input v);
    begin
      @(negedge clk);
      halt_req = v;
    end
  endtask
endmodule

/* File: bench/dfs_top_asserts.sv */
// port assertions for the drive fault supervisor
`timescale 1ns/1ns
module dfs_asserts (
  input wire clk,
  input wire rst_b,
  input wire fault_reset,
  input wire cmd_valid,
  input wire [2:0] cmd_code,
  input wire rsp_valid,
  input wire rsp_ok,
  input wire [15:0] rsp_code,
  input wire err_log,
  input wire [15:0] err_code,
  input wire [2:0] err_class,
  input wire [31:0] err_word,
  input wire [4:0] state_onehot,
  input wire power_active,
  input wire halt_braking
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // command refusals, judged against the state of the taking edge
  // ----------------------------------------------------------------
  a_fault_refuse: assert property (
    cmd_valid && state_onehot == 5'h10 |=> rsp_valid && !rsp_ok && rsp_code == 16'ha308)
    else $error("command in fault state not refused");
  a_unready_enable: assert property (
    cmd_valid && cmd_code == 3'h0 && state_onehot == 5'h01 |=> rsp_code == 16'ha305)
    else $error("enable in unready state not refused");
  a_opmode_needs_op: assert property (
    cmd_valid && cmd_code == 3'h2 && state_onehot[1:0] != 2'h0 |=> rsp_code == 16'ha309)
    else $error("opmode outside operation enabled not refused");
  a_motion_no_power: assert property (
    cmd_valid && cmd_code == 3'h3 && !power_active && !state_onehot[4]
    |=> !rsp_ok && rsp_code == 16'ha310)
    else $error("motion without power stage not refused");
  a_halt_refuse: assert property (
    cmd_valid && halt_braking && state_onehot == 5'h04 |=> rsp_code == 16'ha300)
    else $error("command during halt braking not refused");
  // ----------------------------------------------------------------
  // states and logging
  // ----------------------------------------------------------------
  a_power_states: assert property (
    power_active == (state_onehot == 5'h04 || state_onehot == 5'h08))
    else $error("power stage flag disagrees with state");
  a_class2_fault: assert property (
    err_log && err_class == 3'h2 |-> state_onehot == 5'h10 && err_word[10])
    else $error("class 2 error without fault state");
  a_class1_qstop: assert property (
    err_log && err_class == 3'h1 |-> state_onehot[3] || state_onehot[4])
    else $error("class 1 error without quick stop");
  a_limit_code: assert property (
    err_log && (err_code == 16'ha302 || err_code == 16'ha303) |-> err_class == 3'h1 && err_word[1])
    else $error("limit error with wrong class or bit");
  a_fault_exit: assert property (
    $fell(state_onehot[4]) |-> $past(fault_reset))
    else $error("fault state left without fault reset");
  a_sticky_word: assert property (
    (|($past(err_word) & ~err_word)) |-> $past(fault_reset))
    else $error("status bit cleared without fault reset");
  cover property (err_log && err_class == 3'h2);
  cover property (cmd_valid && halt_braking);
  cover property ($fell(state_onehot[3]));
endmodule

/* File: bench/drive_fault_supervisor_bench.sv */
// self-checking bench for the drive fault supervisor
`timescale 1ns/1ns
`include "dfs_map.vh"
module drive_fault_supervisor_bench;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg lim_p = 1'b0;
  reg lim_n = 1'b0;
  reg [4:0] mon = 5'h00;
  reg usr = 1'b0;
  reg ist = 1'b0;
  reg hoj = 1'b0;
  reg pwr = 1'b0;
  reg still = 1'b1;
  wire cmd_valid, fault_reset, halt_req, rsp_valid, rsp_ok, err_log;
  wire power_active, halt_braking, motion_stop;
  wire [2:0] cmd_code;
  wire [2:0] err_class;
  wire [15:0] rsp_code;
  wire [15:0] err_code;
  wire [31:0] err_word;
  wire [4:0] state_onehot;
  integer err_total = 0;
  integer total_checks = 0;
  integer i;
  localparam [79:0] C2 = {`DFS_CODE_FILT_DIFF, `DFS_CODE_FILT_SPD, `DFS_CODE_FILT_OFS,
    `DFS_CODE_GEAR_STEP, `DFS_CODE_GEAR_SPD};
  always #5 clk = ~clk;
  dfs_top dut (.clk(clk), .rst_b(rst_b), .positive_limit_input(lim_p),
    .negative_limit_input(lim_n), .gear_speed_over(mon[0]), .gear_step_over(mon[1]),
    .filt_offset_over(mon[2]), .filt_speed_over(mon[3]), .filt_diff_over(mon[4]),
    .user_stop_req(usr), .int_stop_req(ist), .homing_or_jog(hoj), .power_ready(pwr),
    .halt_req(halt_req), .standstill(still), .fault_reset(fault_reset),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
    .rsp_code(rsp_code), .err_log(err_log), .err_code(err_code), .err_class(err_class),
    .err_word(err_word), .state_onehot(state_onehot), .power_active(power_active),
    .halt_braking(halt_braking), .motion_stop(motion_stop));
  dfs_host host (.clk(clk), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_code(rsp_code),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .fault_reset(fault_reset),
    .halt_req(halt_req));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task check(input [39:0] seen, input [39:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task cmd(input [2:0] code, input [15:0] exp);
    reg ok;
    reg got;
    reg [15:0] rc;
    begin
      host.send(code, ok, rc, got);
      check({got, ok, rc}, {1'b1, exp == 16'h0000, exp});
    end
  endtask
  task wait_state(input [4:0] s);
    integer n;
    begin
      n = 0;
      while (state_onehot !== s && n < 8) begin
        @(negedge clk);
        n = n + 1;
      end
      check(state_onehot, s);
      if (state_onehot !== s) complete_run;
    end
  endtask
  task wait_err(input [15:0] code, input [2:0] cls);
    integer n;
    begin
      n = 0;
      while (err_log !== 1'b1 && n < 8) begin
        @(negedge clk);
        n = n + 1;
      end
      check({err_log, err_class, err_code}, {1'b1, cls, code});
      if (err_log !== 1'b1) complete_run;
    end
  endtask
  // fault reset, back to ready, then enable again
  task recover;
    begin
      host.clear;
      wait_state(5'h02);
      cmd(`DFS_CMD_ENABLE, `DFS_CODE_NONE);
      wait_state(5'h04);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task sc_reset;
    begin
      check({power_active, err_word}, 33'h0);
      cmd(`DFS_CMD_ENABLE, `DFS_CODE_UNREADY);
      cmd(`DFS_CMD_OPMODE, `DFS_CODE_NOT_OPEN);
      cmd(`DFS_CMD_MOTION, `DFS_CODE_NO_POWER);
      pwr = 1'b1;
      wait_state(5'h02);
      cmd(`DFS_CMD_OPMODE, `DFS_CODE_NOT_OPEN);
      cmd(`DFS_CMD_ENABLE, `DFS_CODE_NONE);
      wait_state(5'h04);
      check(power_active, 1'b1);
      cmd(`DFS_CMD_OPMODE, `DFS_CODE_NONE);
    end
  endtask
  task sc_class2;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        mon[i] = 1'b1;
        wait_err(C2[i*16 +: 16], `DFS_CLASS_FAULT);
        check({err_word[10], state_onehot}, {1'b1, 5'h10});
        cmd(`DFS_CMD_PARAM, `DFS_CODE_FAULT);
        host.clear;
        repeat (2) @(negedge clk);
        check(state_onehot, 5'h10);
        mon[i] = 1'b0;
        recover;
        check(err_word, 32'h0);
      end
    end
  endtask
  task sc_limits;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        lim_p = (i == 0);
        lim_n = (i == 1);
        wait_err(i ? `DFS_CODE_LIM_NEG : `DFS_CODE_LIM_POS, `DFS_CLASS_QSTOP);
        check({err_word[1], power_active, motion_stop, state_onehot}, 8'he8);
        cmd(`DFS_CMD_OPMODE, `DFS_CODE_QSTOP);
        lim_p = 1'b0;
        lim_n = 1'b0;
        repeat (4) @(negedge clk);
        recover;
      end
    end
  endtask
  task sc_stops;
    begin
      usr = 1'b1;
      @(negedge clk);
      usr = 1'b0;
      wait_err(`DFS_CODE_USR_STOP, `DFS_CLASS_QSTOP);
      check({err_word[3], state_onehot}, 6'h28);
      cmd(`DFS_CMD_OPMODE, `DFS_CODE_USR_STOP);
      repeat (20) @(negedge clk);
      check(state_onehot, 5'h08);
      recover;
      // outside homing or jog the internal stop must be ignored
      ist = 1'b1;
      repeat (3) @(negedge clk);
      check({err_log, state_onehot}, 6'h04);
      hoj = 1'b1;
      @(negedge clk);
      ist = 1'b0;
      wait_err(`DFS_CODE_INT_STOP, `DFS_CLASS_QSTOP);
      cmd(`DFS_CMD_OPMODE, `DFS_CODE_INT_STOP);
      hoj = 1'b0;
      recover;
      usr = 1'b1;
      mon[0] = 1'b1;
      @(negedge clk);
      usr = 1'b0;
      wait_err(`DFS_CODE_GEAR_SPD, `DFS_CLASS_FAULT);
      check(state_onehot, 5'h10);
      mon[0] = 1'b0;
      recover;
    end
  endtask
  task sc_halt;
    integer n;
    begin
      still = 1'b0;
      host.halt(1'b1);
      repeat (2) @(negedge clk);
      check(halt_braking, 1'b1);
      cmd(`DFS_CMD_MOTION, `DFS_CODE_HALT_BRAKE);
      host.halt(1'b0);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 4) begin
        @(negedge clk);
        n = n + 1;
      end
      check({rsp_valid, rsp_code}, {1'b1, `DFS_CODE_HALT_BRAKE});
      if (rsp_valid !== 1'b1) complete_run;
      still = 1'b1;
      repeat (2) @(negedge clk);
      check(halt_braking, 1'b0);
    end
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    sc_reset;
    sc_class2;
    sc_limits;
    sc_stops;
    sc_halt;
    complete_run;
  end
endmodule
bind dfs_top dfs_asserts chk (.clk(clk), .rst_b(rst_b), .fault_reset(fault_reset),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
  .rsp_code(rsp_code), .err_log(err_log), .err_code(err_code), .err_class(err_class),
  .err_word(err_word), .state_onehot(state_onehot), .power_active(power_active),
  .halt_braking(halt_braking));

/* File: verilog/dfs_classify.v */
// error classifier: class, code and status bits of same-cycle events
`timescale 1ns/1ns
`include "dfs_map.vh"
module dfs_classify (
  ev,
  max_class,
  code,
  bit_mask
);
  input wire [`DFS_NEV-1:0] ev;
  output reg [2:0] max_class;
  output reg [15:0] code;
  output wire [31:0] bit_mask;

  function [15:0] ev_code;
    input integer i;
    begin
      case (i)
        `DFS_EV_GEAR_SPD: ev_code = `DFS_CODE_GEAR_SPD;
        `DFS_EV_GEAR_STEP: ev_code = `DFS_CODE_GEAR_STEP;
        `DFS_EV_FILT_OFS: ev_code = `DFS_CODE_FILT_OFS;
        `DFS_EV_FILT_SPD: ev_code = `DFS_CODE_FILT_SPD;
        `DFS_EV_FILT_DIFF: ev_code = `DFS_CODE_FILT_DIFF;
        `DFS_EV_LIM_POS: ev_code = `DFS_CODE_LIM_POS;
        `DFS_EV_LIM_NEG: ev_code = `DFS_CODE_LIM_NEG;
        `DFS_EV_USR_STOP: ev_code = `DFS_CODE_USR_STOP;
        default: ev_code = `DFS_CODE_INT_STOP;
      endcase
    end
  endfunction

  function [2:0] ev_class;
    input integer i;
    begin
      if (i <= `DFS_EV_FILT_DIFF)
        ev_class = `DFS_CLASS_FAULT;
      else
        ev_class = `DFS_CLASS_QSTOP;
    end
  endfunction

  function [4:0] ev_bit;
    input integer i;
    begin
      if (i <= `DFS_EV_FILT_DIFF)
        ev_bit = `DFS_BIT_REF;
      else if (i <= `DFS_EV_LIM_NEG)
        ev_bit = `DFS_BIT_LIMIT;
      else
        ev_bit = `DFS_BIT_SWSTOP;
    end
  endfunction

  // ----------------------------------------------------------------
  // per-event status bit
  // ----------------------------------------------------------------
  wire [31:0] part [0:`DFS_NEV-1];
  genvar g;
  generate
    for (g = 0; g < `DFS_NEV; g = g + 1) begin : gen_ev
      if (g == 0) begin : gen_first
        assign part[g] = ev[g] ? (32'h1 << ev_bit(g)) : 32'h0;
      end else begin : gen_rest
        assign part[g] = part[g-1] | (ev[g] ? (32'h1 << ev_bit(g)) : 32'h0);
      end
    end
  endgenerate
  assign bit_mask = part[`DFS_NEV-1];

  // ----------------------------------------------------------------
  // highest class wins, scanned from the top so lowest index wins ties
  // ----------------------------------------------------------------
  integer i;
  always @* begin
    max_class = `DFS_CLASS_NONE;
    code = `DFS_CODE_NONE;
    for (i = `DFS_NEV - 1; i >= 0; i = i - 1) begin
      if (ev[i] && ev_class(i) >= max_class) begin
        max_class = ev_class(i);
        code = ev_code(i);
      end
    end
  end
endmodule

/* File: verilog/dfs_map.vh */
// constants of the drive fault supervisor
`ifndef DFS_MAP_VH
`define DFS_MAP_VH

// ----------------------------------------------------------------
// error codes
// ----------------------------------------------------------------
`define DFS_CODE_NONE 16'h0000
`define DFS_CODE_GEAR_SPD 16'ha060
`define DFS_CODE_GEAR_STEP 16'ha061
`define DFS_CODE_FILT_OFS 16'ha062
`define DFS_CODE_FILT_SPD 16'ha063
`define DFS_CODE_FILT_DIFF 16'ha064
`define DFS_CODE_HALT_BRAKE 16'ha300
`define DFS_CODE_QSTOP 16'ha301
`define DFS_CODE_LIM_POS 16'ha302
`define DFS_CODE_LIM_NEG 16'ha303
`define DFS_CODE_UNREADY 16'ha305
`define DFS_CODE_USR_STOP 16'ha306
`define DFS_CODE_INT_STOP 16'ha307
`define DFS_CODE_FAULT 16'ha308
`define DFS_CODE_NOT_OPEN 16'ha309
`define DFS_CODE_NO_POWER 16'ha310

// ----------------------------------------------------------------
// classes and status bit positions
// ----------------------------------------------------------------
`define DFS_CLASS_NONE 3'h0
`define DFS_CLASS_QSTOP 3'h1
`define DFS_CLASS_FAULT 3'h2
`define DFS_BIT_LIMIT 5'h01
`define DFS_BIT_SWSTOP 5'h03
`define DFS_BIT_REF 5'h0a

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define DFS_CMD_ENABLE 3'h0
`define DFS_CMD_DISABLE 3'h1
`define DFS_CMD_OPMODE 3'h2
`define DFS_CMD_MOTION 3'h3
`define DFS_CMD_PARAM 3'h4

// ----------------------------------------------------------------
// event slots, lowest index wins among equal class
// ----------------------------------------------------------------
`define DFS_NEV 9
`define DFS_EV_GEAR_SPD 0
`define DFS_EV_GEAR_STEP 1
`define DFS_EV_FILT_OFS 2
`define DFS_EV_FILT_SPD 3
`define DFS_EV_FILT_DIFF 4
`define DFS_EV_LIM_POS 5
`define DFS_EV_LIM_NEG 6
`define DFS_EV_USR_STOP 7
`define DFS_EV_INT_STOP 8

`endif

/* File: verilog/dfs_sync.v */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dfs_sync #(
  parameter W = 2
) (
  clk,
  rst_b,
  d,
  q
);
  input wire clk;
  input wire rst_b;
  input wire [W-1:0] d;
  output wire [W-1:0] q;

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // first stage feeds only the second stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule

/* File: verilog/dfs_top.v */
// drive fault supervisor: error logging, stop states and command refusal
`timescale 1ns/1ns
`include "dfs_map.vh"
module dfs_top (
  clk,
  rst_b,
  positive_limit_input,
  negative_limit_input,
  gear_speed_over,
  gear_step_over,
  filt_offset_over,
  filt_speed_over,
  filt_diff_over,
  user_stop_req,
  int_stop_req,
  homing_or_jog,
  power_ready,
  halt_req,
  standstill,
  fault_reset,
  cmd_valid,
  cmd_code,
  rsp_valid,
  rsp_ok,
  rsp_code,
  err_log,
  err_code,
  err_class,
  err_word,
  state_onehot,
  power_active,
  halt_braking,
  motion_stop
);
  input wire clk;
  input wire rst_b;
  input wire positive_limit_input;
  input wire negative_limit_input;
  input wire gear_speed_over;
  input wire gear_step_over;
  input wire filt_offset_over;
  input wire filt_speed_over;
  input wire filt_diff_over;
  input wire user_stop_req;
  input wire int_stop_req;
  input wire homing_or_jog;
  input wire power_ready;
  input wire halt_req;
  input wire standstill;
  input wire fault_reset;
  input wire cmd_valid;
  input wire [2:0] cmd_code;
  output reg rsp_valid;
  output reg rsp_ok;
  output reg [15:0] rsp_code;
  output reg err_log;
  output reg [15:0] err_code;
  output reg [2:0] err_class;
  output reg [31:0] err_word;
  output wire [4:0] state_onehot;
  output wire power_active;
  output wire halt_braking;
  output wire motion_stop;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [4:0] ST_UNREADY = 5'h01;
  localparam [4:0] ST_READY = 5'h02;
  localparam [4:0] ST_OPEN = 5'h04;
  localparam [4:0] ST_QSTOP = 5'h08;
  localparam [4:0] ST_FAULT = 5'h10;

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg usr_stop_r;
  reg int_stop_r;
  reg halt_brake_r;
  reg halt_prev_r;
  reg [1:0] lim_prev_r;
  reg [4:0] ref_prev_r;
  reg [15:0] err_code_nxt;
  reg [2:0] err_class_nxt;
  reg rsp_ok_nxt;
  reg [15:0] rsp_code_nxt;

  wire [1:0] lim_s;
  wire [4:0] ref_lvl;
  wire [`DFS_NEV-1:0] ev;
  wire [2:0] ev_class;
  wire [15:0] ev_code;
  wire [31:0] ev_bits;
  wire halt_drop;
  wire int_stop_ev;
  wire cond_clear;

  // ----------------------------------------------------------------
  // limit pins come from outside, so they are synchronised first
  // ----------------------------------------------------------------
  dfs_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({negative_limit_input, positive_limit_input}),
    .q(lim_s)
  );

  assign ref_lvl = {filt_diff_over, filt_speed_over, filt_offset_over,
                    gear_step_over, gear_speed_over};

  // ----------------------------------------------------------------
  // edge detection: a held limit or monitor condition logs once, not every cycle
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lim_prev_r <= 2'h0;
      ref_prev_r <= 5'h00;
      halt_prev_r <= 1'b0;
    end else begin
      lim_prev_r <= lim_s;
      ref_prev_r <= ref_lvl;
      halt_prev_r <= halt_req;
    end
  end

  // internal stop only counts in homing or jog
  assign int_stop_ev = int_stop_req & homing_or_jog;

  assign ev[`DFS_EV_GEAR_SPD] = ref_lvl[0] & ~ref_prev_r[0];
  assign ev[`DFS_EV_GEAR_STEP] = ref_lvl[1] & ~ref_prev_r[1];
  assign ev[`DFS_EV_FILT_OFS] = ref_lvl[2] & ~ref_prev_r[2];
  assign ev[`DFS_EV_FILT_SPD] = ref_lvl[3] & ~ref_prev_r[3];
  assign ev[`DFS_EV_FILT_DIFF] = ref_lvl[4] & ~ref_prev_r[4];
  assign ev[`DFS_EV_LIM_POS] = lim_s[0] & ~lim_prev_r[0];
  assign ev[`DFS_EV_LIM_NEG] = lim_s[1] & ~lim_prev_r[1];
  assign ev[`DFS_EV_USR_STOP] = user_stop_req;
  assign ev[`DFS_EV_INT_STOP] = int_stop_ev;

  dfs_classify u_cls (
    .ev(ev),
    .max_class(ev_class),
    .code(ev_code),
    .bit_mask(ev_bits)
  );

  // state exit and err_code clear on fault reset wait until no fault condition or limit is still present
  assign cond_clear = ~(|ref_lvl) & ~(|lim_s);

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_UNREADY: begin
        if (power_ready)
          state_nxt = ST_READY;
      end
      ST_READY: begin
        if (!power_ready)
          state_nxt = ST_UNREADY;
        else if (cmd_valid && cmd_code == `DFS_CMD_ENABLE)
          state_nxt = ST_OPEN;
      end
      ST_OPEN: begin
        if (cmd_valid && cmd_code == `DFS_CMD_DISABLE && !halt_brake_r)
          state_nxt = ST_READY;
      end
      ST_QSTOP: begin
        if (fault_reset && !usr_stop_r && !int_stop_r && cond_clear)
          state_nxt = ST_READY;
        else if (fault_reset && cond_clear && !user_stop_req && !int_stop_ev)
          state_nxt = ST_READY;
      end
      ST_FAULT: begin
        if (fault_reset && cond_clear)
          state_nxt = ST_READY;
      end
      default: state_nxt = ST_UNREADY;
    endcase
    // class decides over any ordinary move; fault outranks quick stop
    if (ev_class >= `DFS_CLASS_FAULT)
      state_nxt = ST_FAULT;
    else if (ev_class == `DFS_CLASS_QSTOP && state_r != ST_FAULT)
      state_nxt = ST_QSTOP;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      state_r <= ST_UNREADY;
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // software stop memory, set wins over fault reset
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      usr_stop_r <= 1'b0;
      int_stop_r <= 1'b0;
    end else begin
      usr_stop_r <= user_stop_req | (usr_stop_r & ~fault_reset);
      int_stop_r <= int_stop_ev | (int_stop_r & ~fault_reset);
    end
  end

  // ----------------------------------------------------------------
  // halt braking: active from halt request in operation enabled until standstill or leaving that state
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      halt_brake_r <= 1'b0;
    else if (state_r != ST_OPEN || standstill)
      halt_brake_r <= 1'b0;
    else if (halt_req)
      halt_brake_r <= 1'b1;
  end

  // halt removed before standstill is answered like a refused command
  assign halt_drop = halt_prev_r & ~halt_req & halt_brake_r & ~standstill;

  // ----------------------------------------------------------------
  // error logging and sticky status word
  // ----------------------------------------------------------------
  always @* begin
    err_code_nxt = err_code;
    err_class_nxt = err_class;
    if (|ev) begin
      err_code_nxt = ev_code;
      err_class_nxt = ev_class;
    end else if (fault_reset && cond_clear) begin
      err_code_nxt = `DFS_CODE_NONE;
      err_class_nxt = `DFS_CLASS_NONE;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_log <= 1'b0;
      err_code <= `DFS_CODE_NONE;
      err_class <= `DFS_CLASS_NONE;
      err_word <= 32'h0000_0000;
    end else begin
      err_log <= |ev;
      err_code <= err_code_nxt;
      err_class <= err_class_nxt;
      // a bit set in the clearing cycle survives the clear
      if (fault_reset)
        err_word <= ev_bits;
      else
        err_word <= err_word | ev_bits;
    end
  end

  // ----------------------------------------------------------------
  // command check: first matching refusal wins
  // ----------------------------------------------------------------
  always @* begin
    rsp_ok_nxt = 1'b1;
    rsp_code_nxt = `DFS_CODE_NONE;
    if (state_r == ST_FAULT) begin
      rsp_ok_nxt = 1'b0;
      rsp_code_nxt = `DFS_CODE_FAULT;
    end else if (state_r == ST_QSTOP && cmd_code != `DFS_CMD_DISABLE) begin
      rsp_ok_nxt = 1'b0;
      if (usr_stop_r)
        rsp_code_nxt = `DFS_CODE_USR_STOP;
      else if (int_stop_r)
        rsp_code_nxt = `DFS_CODE_INT_STOP;
      else
        rsp_code_nxt = `DFS_CODE_QSTOP;
    end else if (halt_brake_r) begin
      rsp_ok_nxt = 1'b0;
      rsp_code_nxt = `DFS_CODE_HALT_BRAKE;
    end else if (cmd_code == `DFS_CMD_ENABLE && state_r == ST_UNREADY) begin
      rsp_ok_nxt = 1'b0;
      rsp_code_nxt = `DFS_CODE_UNREADY;
    end else if (cmd_code == `DFS_CMD_OPMODE && state_r != ST_OPEN) begin
      rsp_ok_nxt = 1'b0;
      rsp_code_nxt = `DFS_CODE_NOT_OPEN;
    end else if (cmd_code == `DFS_CMD_MOTION && !power_active) begin
      rsp_ok_nxt = 1'b0;
      rsp_code_nxt = `DFS_CODE_NO_POWER;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_ok <= 1'b0;
      rsp_code <= `DFS_CODE_NONE;
    end else if (cmd_valid) begin
      rsp_valid <= 1'b1;
      rsp_ok <= rsp_ok_nxt;
      rsp_code <= rsp_code_nxt;
    end else if (halt_drop) begin
      rsp_valid <= 1'b1;
      rsp_ok <= 1'b0;
      rsp_code <= `DFS_CODE_HALT_BRAKE;
    end else begin
      rsp_valid <= 1'b0;
      rsp_ok <= 1'b0;
      rsp_code <= `DFS_CODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign state_onehot = state_r;
  assign power_active = (state_r == ST_OPEN) | (state_r == ST_QSTOP);
  assign halt_braking = halt_brake_r;
  // motion stops in quick stop or fault; brake ramp is the motor loop's job
  assign motion_stop = (state_r == ST_QSTOP) | (state_r == ST_FAULT);
endmodule
